//--- rtl/lds_consts.svh
`ifndef LDS_CONSTS_SVH
`define LDS_CONSTS_SVH
`define LDS_CHIP_ADDR 7'h4C
`define LDS_REG_TEST 8'h0C
`define LDS_TEST_LAUNCH 8'h01
`define LDS_BIT_LAST 3'h7
`define LDS_TEST_SCL_EDGES 4'hA
`define LDS_PASS_ALL 8'h00
`endif

//--- rtl/lds_pkg.sv
`default_nettype none
package lds_pkg;
    typedef enum logic [6:0] {
        LDS_IDLE = 7'b0000001,
        LDS_ADDR = 7'b0000010,
        LDS_ACK = 7'b0000100,
        LDS_RX = 7'b0001000,
        LDS_TX = 7'b0010000,
        LDS_MACK = 7'b0100000,
        LDS_IGN = 7'b1000000
    } lds_state_t;
endpackage
`default_nettype wire

//--- rtl/lds_sync.sv
`default_nettype none
module lds_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- rtl/lds_slave.sv
`include "lds_consts.svh"
`default_nettype none
module lds_slave import lds_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic bus_busy,
    output logic [7:0] test_reg,
    output logic test_running,
    output logic [7:0] reg_index,
    input wire logic [7:0] led_fault
);
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    lds_state_t st_q;
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    logic rw_q, have_idx_q;
    logic [3:0] tcnt_q;
    logic [7:0] fault_acc_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic full_q, byte_done;
    logic [7:0] rd_word;
    logic [1:0] pin_raw, pin_s;

    // Only the test register exists here; other indexes read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] idx, input logic [7:0] val);
        read_mux = (idx == `LDS_REG_TEST) ? val : 8'h00;
    endfunction

    // Both pins take the same two-stage path so their edges stay aligned
    assign pin_raw = {sda_in, scl_in};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        lds_sync u_sync (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .async_in(pin_raw[g]),
            .sync_out(pin_s[g])
        );
    end
    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign byte_done = scl_fall & full_q;
    assign rd_word = read_mux(reg_index, test_reg);

    // Counter reads zero both empty and full; this flag marks a full byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            full_q <= 1'b0;
        end else if (start_c || stop_c) begin
            full_q <= 1'b0;
        end else if (scl_rise && cnt_q == `LDS_BIT_LAST
                     && (st_q == LDS_ADDR || st_q == LDS_RX)) begin
            full_q <= 1'b1;
        end else if (scl_fall) begin
            full_q <= 1'b0;
        end
    end

    // Bus occupancy
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bus_busy <= 1'b0;
        end else if (start_c) begin
            bus_busy <= 1'b1;
        end else if (stop_c) begin
            bus_busy <= 1'b0;
        end
    end

    // Protocol engine; start always wins, also mid-transfer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= LDS_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            rw_q <= 1'b0;
            have_idx_q <= 1'b0;
            reg_index <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            st_q <= LDS_ADDR;
            cnt_q <= 3'h0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            st_q <= LDS_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (st_q)
                LDS_ADDR, LDS_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 3'h1;
                    end else if (byte_done) begin
                        // Eighth clock has fallen; the ninth slot begins
                        if (st_q == LDS_ADDR) begin
                            if (sh_q[7:1] == `LDS_CHIP_ADDR) begin
                                rw_q <= sh_q[0];
                                st_q <= LDS_ACK;
                                sda_out <= 1'b0;
                                sda_oe <= 1'b1;
                            end else begin
                                st_q <= LDS_IGN;
                            end
                        end else begin
                            if (!have_idx_q) begin
                                reg_index <= sh_q;
                                have_idx_q <= 1'b1;
                            end
                            st_q <= LDS_ACK;
                            sda_out <= 1'b0;
                            sda_oe <= 1'b1;
                        end
                    end
                end
                LDS_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 3'h0;
                        if (rw_q) begin
                            st_q <= LDS_TX;
                            sh_q <= rd_word;
                            sda_out <= rd_word[7];
                            sda_oe <= 1'b1;
                        end else begin
                            st_q <= LDS_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                LDS_TX: begin
                    if (scl_fall) begin
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == `LDS_BIT_LAST) begin
                            st_q <= LDS_MACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_out <= sh_q[6];
                        end
                    end
                end
                LDS_MACK: begin
                    if (scl_rise) begin
                        // Nack ends the read; ack repeats the same register
                        if (sda_s) begin
                            st_q <= LDS_IGN;
                        end else begin
                            st_q <= LDS_ACK;
                        end
                    end
                end
                LDS_IGN, LDS_IDLE: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    st_q <= LDS_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
            if (st_q == LDS_IDLE) begin
                have_idx_q <= 1'b0;
            end
        end
    end

    // Register write and self-test; test counts serial clock edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            test_reg <= 8'h00;
            test_running <= 1'b0;
            tcnt_q <= 4'h0;
            fault_acc_q <= 8'h00;
        end else if (st_q == LDS_RX && byte_done && have_idx_q
                     && reg_index == `LDS_REG_TEST) begin
            test_reg <= sh_q;
            if (sh_q == `LDS_TEST_LAUNCH) begin
                test_running <= 1'b1;
                tcnt_q <= 4'h0;
                fault_acc_q <= `LDS_PASS_ALL;
            end
        end else if (test_running && scl_rise) begin
            fault_acc_q <= fault_acc_q | led_fault;
            tcnt_q <= tcnt_q + 4'h1;
            if (tcnt_q == `LDS_TEST_SCL_EDGES) begin
                test_running <= 1'b0;
                test_reg <= fault_acc_q | led_fault;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/lds_slave_properties.sv
`default_nettype none
module lds_slave_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic bus_busy,
    input wire logic [7:0] test_reg,
    input wire logic test_running,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] led_fault
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] n_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !test_running) n_q <= 4'h0;
        else if ($rose(scl_in)) n_q <= n_q + 4'h1;
    end
    sequence start_s; $fell(sda_in) && scl_in && $past(scl_in); endsequence
    sequence stop_s; $rose(sda_in) && scl_in && $past(scl_in); endsequence
    sequence ack_s; $rose(sda_oe) && !sda_out; endsequence
    sequence ninth_end_s; 1'b1 ##[1:12] $fell(scl_in); endsequence
    start_busy_a: assert property (start_s |-> ##[1:6] bus_busy)
        else $error("no busy");
    stop_idle_a: assert property (stop_s |-> ##[1:6] !bus_busy)
        else $error("no idle");
    drive_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved");
    ack_hold_a: assert property (ack_s |-> sda_oe throughout ninth_end_s)
        else $error("ack short");
    idle_free_a: assert property (!bus_busy |-> !sda_oe)
        else $error("idle drive");
    run_index_a: assert property ($rose(test_running) |-> reg_index == 8'h0C)
        else $error("bad launch");
    run_len_a: assert property ($fell(test_running) |-> n_q inside {[9:12]})
        else $error("bad length");
    test_result_a: assert property ($fell(test_running) |-> ##[0:2] test_reg == led_fault)
        else $error("bad result");
endmodule
bind lds_slave lds_slave_properties chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_busy(bus_busy), .test_reg(test_reg), .test_running(test_running),
    .reg_index(reg_index), .led_fault(led_fault));
`default_nettype wire

//--- tb/lds_mst.sv
`default_nettype none
module lds_mst (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic start_c();
        sda_rel <= 1'b1;
        // Slave lets go of its ack three cycles after the fall; wait past that
        w(6);
        scl <= 1'b1;
        w(3);
        sda_rel <= 1'b0;
        w(3);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        sda_rel <= 1'b0;
        w(6);
        scl <= 1'b1;
        w(3);
        sda_rel <= 1'b1;
        w(3);
    endtask
    // Long low phase leaves the slave's synchroniser room
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
        output logic nack);
        logic [8:0] got;
        for (int i = 8; i >= 0; i--) begin
            w(3);
            sda_rel <= (i == 0) ? mack : tx[i-1];
            w(3);
            scl <= 1'b1;
            w(1);
            got = {got[7:0], sda_line};
            w(1);
            scl <= 1'b0;
        end
        rx = got[8:1];
        nack = got[0];
    endtask
endmodule
`default_nettype wire

//--- tb/test_lds_slave.sv
`default_nettype none
module test_lds_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk;
    logic sys_rst;
    logic scl;
    logic sda_rel;
    logic sda_out;
    logic sda_oe;
    logic bus_busy;
    logic test_running;
    logic [7:0] test_reg;
    logic [7:0] reg_index;
    logic [7:0] led_fault;
    int bad_count;
    int n_checks;
    wire sda_line = sda_rel & ~(sda_oe & ~sda_out);
    lds_slave lds_slave_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy),
        .test_reg(test_reg), .test_running(test_running), .reg_index(reg_index),
        .led_fault(led_fault));
    lds_mst mst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xb(input logic [7:0] tx, input logic acked);
        logic [7:0] rx;
        logic nack;
        mst.xfer(tx, 1'b1, rx, nack);
        chk("ack", {7'h0, acked}, {7'h0, !nack});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] rx;
        logic nack;
        mst.start_c();
        xb(8'h98, 1'b1);
        xb(idx, 1'b1);
        mst.start_c();
        xb(8'h99, 1'b1);
        mst.xfer(8'hFF, 1'b1, rx, nack);
        chk("read data", exp, rx);
        mst.stop_c();
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        sys_rst <= 1'b1;
        led_fault <= 8'h05;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("outputs", 8'h00, {bus_busy, test_running, sda_oe, 5'h0});
        chk("registers", 8'h00, test_reg | reg_index);
        $display("reset test done");
        mst.start_c();
        xb(8'h9A, 1'b0);
        xb(8'h0C, 1'b0);
        chk("busy", 8'h01, {7'h0, bus_busy});
        mst.stop_c();
        repeat (8) @(posedge sys_clk);
        chk("idle", 8'h00, {7'h0, bus_busy});
        $display("address test done");
        // Standby and boost enables live outside this block
        mst.start_c();
        xb(8'h98, 1'b1);
        xb(8'h0C, 1'b1);
        xb(8'h01, 1'b1);
        chk("index", 8'h0C, reg_index);
        mst.stop_c();
        chk("running", 8'h01, {7'h0, test_running});
        $display("launch test done");
        // Bench link clock is fast; the test counts edges, not time
        rd(8'h0C, 8'h05);
        chk("result", 8'h05, test_reg);
        chk("test stopped", 8'h00, {7'h0, test_running});
        rd(8'h03, 8'h00);
        $display("read test done");
        end_of_test();
    end
endmodule
`default_nettype wire
